// ### ivpr_pkg.sv
// Constants for the interrupt vector and priority resolver.
// Assumes one system clock domain; imported nowhere, used by scope.
package ivpr_pkg;
	localparam int NUM_VEC = 17;
	localparam int VEC_W = 5;
	localparam int LVL_W = 2;
	localparam int ADDR_W = 21;
	localparam int BASE_W = 16;
	// Base counts in table steps; entry = base shifted up plus 2*vector
	localparam int BASE_SHIFT = 7;
	localparam logic [BASE_W-1:0] BASE_RESET = 16'h0000;
	localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
	localparam logic [VEC_W-1:0] VEC_WDOG = 5'h01;
	localparam logic [VEC_W-1:0] VEC_RSVD = 5'h0E;
	localparam logic [VEC_W-1:0] VEC_DBG_FIRST = 5'h06;
	localparam logic [VEC_W-1:0] VEC_DBG_LAST = 5'h0A;
	localparam logic [VEC_W-1:0] VEC_LVD = 5'h0F;
	localparam logic [VEC_W-1:0] VEC_PLL = 5'h10;
	localparam logic [LVL_W-1:0] LVL_FIXED_HI = 2'h3;
	localparam logic [LVL_W-1:0] LVL_SWI2 = 2'h2;
	localparam logic [LVL_W-1:0] LVL_SWI1 = 2'h1;
	localparam logic [LVL_W-1:0] LVL_SWI0 = 2'h0;
	localparam logic [LVL_W-1:0] LVL_PROG_MIN = 2'h1;
	localparam logic [LVL_W-1:0] LVL_RESET = 2'h1;
	typedef enum logic [1:0] {IVPR_IDLE, IVPR_PRESENT} ivpr_state_t;
endpackage : ivpr_pkg

// ### ivpr_level_map.sv
// Per-vector level table: fixed levels and software-programmed levels.
// Assumes the level inputs come from same-clock control logic.
`timescale 1ns/1ps
module ivpr_level_map (
	input wire logic [ivpr_pkg::NUM_VEC*ivpr_pkg::LVL_W-1:0] prog_level_i,
	output logic [ivpr_pkg::NUM_VEC*ivpr_pkg::LVL_W-1:0] level_o,
	output logic [ivpr_pkg::NUM_VEC-1:0] usable_o
);
	localparam int W = ivpr_pkg::LVL_W;

	// Clamp level 0 up: programmable sources live in levels 1-3
	function automatic logic [ivpr_pkg::LVL_W-1:0] clamp_prog(
		input logic [ivpr_pkg::LVL_W-1:0] lvl);
		clamp_prog = (lvl < ivpr_pkg::LVL_PROG_MIN) ?
			ivpr_pkg::LVL_PROG_MIN : lvl;
	endfunction : clamp_prog

	genvar g;
	generate
		for (g = 0; g < ivpr_pkg::NUM_VEC; g++) begin : g_vec
			logic [ivpr_pkg::LVL_W-1:0] pl;
			assign pl = prog_level_i[g*W +: W];
			always_comb begin
				usable_o[g] = 1'b1;
				if (g <= 1) begin
					// Resets enter by the reset path, not as requests
					level_o[g*W +: W] = ivpr_pkg::LVL_FIXED_HI;
					usable_o[g] = 1'b0;
				end else if (g <= 5) begin
					level_o[g*W +: W] = ivpr_pkg::LVL_FIXED_HI;
				end else if (g <= 10) begin
					level_o[g*W +: W] = clamp_prog(pl);
				end else if (g == 11) begin
					level_o[g*W +: W] = ivpr_pkg::LVL_SWI2;
				end else if (g == 12) begin
					level_o[g*W +: W] = ivpr_pkg::LVL_SWI1;
				end else if (g == 13) begin
					level_o[g*W +: W] = ivpr_pkg::LVL_SWI0;
				end else if (g == 14) begin
					level_o[g*W +: W] = ivpr_pkg::LVL_SWI0;
					usable_o[g] = 1'b0;
				end else begin
					level_o[g*W +: W] = clamp_prog(pl);
				end
			end
		end
	endgenerate
endmodule : ivpr_level_map

// ### ivpr_top.sv
// Interrupt vector and priority resolver facing the processor core.
// Assumes requests and levels are same-clock levels from peripherals
// and control logic; the core pulses ACK_I once it fetched the entry.
`timescale 1ns/1ps
module ivpr_top (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic [ivpr_pkg::NUM_VEC-1:0] IRQ_REQ_I,
	input wire logic [ivpr_pkg::NUM_VEC*ivpr_pkg::LVL_W-1:0] IRQ_LEVEL_I,
	input wire logic [ivpr_pkg::BASE_W-1:0] VECTOR_TABLE_BASE_I,
	input wire logic WDOG_RESET_I,
	input wire logic ACK_I,
	output logic VALID_O,
	output logic [ivpr_pkg::VEC_W-1:0] VECTOR_O,
	output logic [ivpr_pkg::LVL_W-1:0] LEVEL_O,
	output logic [ivpr_pkg::ADDR_W-1:0] ENTRY_ADDR_O,
	output logic [ivpr_pkg::ADDR_W-1:0] RESET_ADDR_O
);
	localparam int W = ivpr_pkg::LVL_W;
	localparam int N = ivpr_pkg::NUM_VEC;
	localparam int NUM_LVL = 1 << ivpr_pkg::LVL_W;

	//**********************************************
	// Internal signals
	//**********************************************
	logic [N*W-1:0] level;
	logic [N-1:0] usable;
	logic [N-1:0] eligible;
	logic [NUM_LVL-1:0] lvl_busy;
	logic found;
	logic [ivpr_pkg::VEC_W-1:0] win_vec;
	logic [ivpr_pkg::LVL_W-1:0] win_lvl;
	ivpr_pkg::ivpr_state_t state;
	ivpr_pkg::ivpr_state_t next_state;
	logic capture;
	logic wdog_seen;
	logic [ivpr_pkg::VEC_W-1:0] reset_vec;

	//**********************************************
	// Helpers
	//**********************************************
	// Level of one vector, read from the packed per-vector table
	function automatic logic [ivpr_pkg::LVL_W-1:0] level_of(
		input logic [ivpr_pkg::NUM_VEC*ivpr_pkg::LVL_W-1:0] tbl,
		input int idx);
		level_of = tbl[idx*ivpr_pkg::LVL_W +: ivpr_pkg::LVL_W];
	endfunction : level_of

	// Table entry address, two words per entry
	function automatic logic [ivpr_pkg::ADDR_W-1:0] entry_addr(
		input logic [ivpr_pkg::BASE_W-1:0] base,
		input logic [ivpr_pkg::VEC_W-1:0] vec);
		logic [ivpr_pkg::ADDR_W-1:0] b;
		logic [ivpr_pkg::ADDR_W-1:0] off;
		b = {base[ivpr_pkg::ADDR_W-ivpr_pkg::BASE_SHIFT-1:0],
			{ivpr_pkg::BASE_SHIFT{1'b0}}};
		off = {{(ivpr_pkg::ADDR_W-ivpr_pkg::VEC_W-1){1'b0}}, vec, 1'b0};
		entry_addr = b + off;
	endfunction : entry_addr

	//**********************************************
	// Level table
	//**********************************************
	ivpr_level_map u_map (
		.prog_level_i(IRQ_LEVEL_I),
		.level_o(level),
		.usable_o(usable)
	);

	//**********************************************
	// Eligibility
	//**********************************************
	genvar g;
	generate
		// Reserved and reset vectors never compete as requests
		for (g = 0; g < N; g++) begin : g_elig
			assign eligible[g] = IRQ_REQ_I[g] && usable[g];
		end
		// One busy flag per level keeps the level pick shallow
		for (g = 0; g < NUM_LVL; g++) begin : g_busy
			always_comb begin
				lvl_busy[g] = 1'b0;
				for (int i = 0; i < N; i++) begin
					if (eligible[i] && level_of(level, i) == W'(g)) begin
						lvl_busy[g] = 1'b1;
					end
				end
			end
		end
	endgenerate

	//**********************************************
	// Priority resolution
	//**********************************************
	// Highest busy level wins over every lower one
	always_comb begin
		found = |eligible;
		win_lvl = ivpr_pkg::LVL_SWI0;
		for (int l = 0; l < NUM_LVL; l++) begin
			if (lvl_busy[l]) begin
				win_lvl = W'(l);
			end
		end
	end

	// Downward scan: the smallest vector at the winning level stays
	always_comb begin
		win_vec = ivpr_pkg::VEC_RESET;
		for (int i = N - 1; i >= 0; i--) begin
			if (eligible[i] && level_of(level, i) == win_lvl) begin
				win_vec = ivpr_pkg::VEC_W'(i);
			end
		end
	end

	//**********************************************
	// Capture
	//**********************************************
	// Only from idle, so a late higher request cannot tear a fetch
	assign capture = (state == ivpr_pkg::IVPR_IDLE) && found;

	//**********************************************
	// Next state
	//**********************************************
	always_comb begin
		next_state = state;
		case (state)
			ivpr_pkg::IVPR_IDLE: begin
				if (found) begin
					next_state = ivpr_pkg::IVPR_PRESENT;
				end
			end
			ivpr_pkg::IVPR_PRESENT: begin
				// Ack closes the fetch; one idle cycle before the next
				if (ACK_I) begin
					next_state = ivpr_pkg::IVPR_IDLE;
				end
			end
			default: begin
				next_state = ivpr_pkg::IVPR_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= ivpr_pkg::IVPR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Decoded from state, so it drops right after the ack edge
	assign VALID_O = (state == ivpr_pkg::IVPR_PRESENT);

	//**********************************************
	// Output registers
	//**********************************************
	// Frozen from capture until the core acknowledges
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			VECTOR_O <= ivpr_pkg::VEC_RESET;
		end else if (capture) begin
			VECTOR_O <= win_vec;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			LEVEL_O <= ivpr_pkg::LVL_SWI0;
		end else if (capture) begin
			LEVEL_O <= win_lvl;
		end
	end

	// Base is sampled once, at capture
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ENTRY_ADDR_O <= '0;
		end else if (capture) begin
			ENTRY_ADDR_O <= entry_addr(VECTOR_TABLE_BASE_I,
				win_vec);
		end
	end

	//**********************************************
	// Watchdog cause
	//**********************************************
	// Same-clock level latched until the next chip reset
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wdog_seen <= 1'b0;
		end else if (WDOG_RESET_I) begin
			wdog_seen <= 1'b1;
		end
	end

	//**********************************************
	// Reset entry
	//**********************************************
	// A watchdog cause steers the fetch to the second entry
	assign reset_vec = (wdog_seen || WDOG_RESET_I) ? ivpr_pkg::VEC_WDOG :
		ivpr_pkg::VEC_RESET;

	// Fetch address after reset; entries 0/1 at the current table base
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RESET_ADDR_O <= '0;
		end else begin
			RESET_ADDR_O <= entry_addr(VECTOR_TABLE_BASE_I, reset_vec);
		end
	end
endmodule : ivpr_top

// ### ivpr_properties.sv
// Timing and value checks on the resolver's core-facing outputs.
// Assumes binding into ivpr_top on its single clock.
`timescale 1ns/1ps
module ivpr_properties (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic [16:0] IRQ_REQ_I,
	input wire logic [15:0] VECTOR_TABLE_BASE_I,
	input wire logic ACK_I,
	input wire logic VALID_O,
	input wire logic [4:0] VECTOR_O,
	input wire logic [1:0] LEVEL_O,
	input wire logic [20:0] ENTRY_ADDR_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// Vectors 0, 1 and 14 never request
	wire logic [16:0] rq = IRQ_REQ_I & 17'h1BFFC;
	property p_take; !VALID_O && |rq |=> VALID_O; endproperty
	a_take: assert property (p_take) else $error("not taken");
	property p_idle; !VALID_O && !(|rq) |=> !VALID_O; endproperty
	a_idle: assert property (p_idle) else $error("spurious");
	property p_hold;
		VALID_O && !ACK_I |=> VALID_O && $stable(VECTOR_O) &&
			$stable(LEVEL_O) && $stable(ENTRY_ADDR_O);
	endproperty
	a_hold: assert property (p_hold) else $error("not held");
	property p_gap; VALID_O && ACK_I |=> !VALID_O; endproperty
	a_gap: assert property (p_gap) else $error("no gap");
	property p_addr; VALID_O |-> ENTRY_ADDR_O ==
		21'({VECTOR_TABLE_BASE_I, 7'h00} + 2 * VECTOR_O); endproperty
	a_addr: assert property (p_addr) else $error("address");
	property p_rsvd; VALID_O |-> !(VECTOR_O inside {5'h00, 5'h01, 5'h0E});
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved");
	property p_fix;
		VALID_O && VECTOR_O inside {[5'h02:5'h05]} |-> LEVEL_O == 2'h3;
	endproperty
	a_fix: assert property (p_fix) else $error("fixed level");
	property p_sw; VALID_O && VECTOR_O inside {[5'h0B:5'h0D]} |->
		LEVEL_O == 2'(5'h0D - VECTOR_O); endproperty
	a_sw: assert property (p_sw) else $error("sw level");
	property p_prog;
		VALID_O && VECTOR_O inside {[5'h06:5'h0A], 5'h0F, 5'h10} |->
			LEVEL_O != 2'h0;
	endproperty
	a_prog: assert property (p_prog) else $error("prog level");
	// Vector 2 is at the top level with the smallest number
	property p_top; !VALID_O && rq[2] |=> VECTOR_O == 5'h02; endproperty
	a_top: assert property (p_top) else $error("top vector");
endmodule : ivpr_properties
bind ivpr_top ivpr_properties u_ivpr_properties (
	.CORE_CLK_I(CORE_CLK_I),
	.RST_N_I(RST_N_I),
	.IRQ_REQ_I(IRQ_REQ_I),
	.VECTOR_TABLE_BASE_I(VECTOR_TABLE_BASE_I),
	.ACK_I(ACK_I),
	.VALID_O(VALID_O),
	.VECTOR_O(VECTOR_O),
	.LEVEL_O(LEVEL_O),
	.ENTRY_ADDR_O(ENTRY_ADDR_O)
);

// ### ivpr_core_model.sv
// Core model: acknowledges each presented entry after a set delay.
// Assumes the resolver's valid output and the bench clock.
`timescale 1ns/1ps
module ivpr_core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic valid_i,
	input wire logic [3:0] dly_i,
	input wire logic [4:0] vector_i,
	output logic ack_o,
	output logic sub_jump_o
);
	int n;
	// Software fills entries 0-1 with jumps, all others with
	// subroutine jumps; reports the kind found at the fetched entry
	always_comb sub_jump_o = (vector_i > 5'h01);
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			n <= 0;
			ack_o <= 1'b0;
		end else begin
			ack_o <= #1 valid_i && !ack_o && n == dly_i;
			n <= (valid_i && !ack_o) ? n + 1 : 0;
		end
	end
endmodule : ivpr_core_model

// ### testbench.sv
// Self-checking bench: priority rows, hold and reset-address cases.
// Assumes the package, ivpr_top and the core model are compiled.
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst_n = 0, wd = 0, ack, valid, sj;
	logic [16:0] rq = '0;
	// Vector 16 at 3, vector 8 at 2, vector 7 at 0 (read as 1)
	logic [33:0] lv = 34'h355561555;
	logic [15:0] base = 16'h0003;
	logic [3:0] dly = 4'h0;
	logic [4:0] vec;
	logic [1:0] lvl;
	logic [20:0] ea, ra;
	int failures = 0, check_count = 0;
	// Row: requests, expected vector, expected level
	logic [23:0] t[9] = '{24'h04040F, 24'h1C002E, 24'h100034, 24'h00220B,
		24'h840043, 24'h2801B1, 24'h420029, 24'h08401D, 24'h0C8022};
	ivpr_top u_ivpr_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .IRQ_REQ_I(rq),
		.IRQ_LEVEL_I(lv), .VECTOR_TABLE_BASE_I(base), .WDOG_RESET_I(wd),
		.ACK_I(ack), .VALID_O(valid), .VECTOR_O(vec), .LEVEL_O(lvl),
		.ENTRY_ADDR_O(ea), .RESET_ADDR_O(ra));
	ivpr_core_model u_ivpr_core_model (.clk_i(clk), .rst_n_i(rst_n),
		.valid_i(valid), .dly_i(dly), .vector_i(vec), .ack_o(ack),
		.sub_jump_o(sj));
	initial forever #4 clk = ~clk;
	task automatic chk(input string s, input logic [20:0] g, e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// Bounded wait; a timeout shows up as a valid mismatch
	task automatic await(input logic v);
		for (int k = 0; k < 50 && valid !== v; k++) @(posedge clk) #1;
		chk("valid", valid, v);
	endtask : await
	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		failures++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1;
		@(posedge clk) #1;
		chk("reset addr", ra, 21'h000180);
		foreach (t[i]) begin
			dly = 4'(i);
			rq = t[i][23:7];
			await(1);
			chk("vector", vec, t[i][6:2]);
			chk("level", lvl, t[i][1:0]);
			chk("entry", ea, 21'h000180 + 2 * t[i][6:2]);
			chk("sub jump", sj, 1'b1);
			rq = '0;
			await(0);
			$display("row %0d done", i);
		end
		rq = 17'h01000;
		await(1);
		rq = 17'h01010;
		repeat (2) @(posedge clk) #1;
		chk("held", vec, 5'h0C);
		await(0);
		await(1);
		chk("next", vec, 5'h04);
		rq = '0;
		await(0);
		$display("hold test done");
		// Vector 16 down to level 1, vector 15 up to level 2
		lv[33:30] = 4'h6;
		rq = 17'h18000;
		await(1);
		chk("prog vector", vec, 5'h0F);
		chk("prog level", lvl, 2'h2);
		rq = '0;
		await(0);
		$display("level test done");
		rst_n = 0;
		base = 16'h0000;
		wd = 1;
		repeat (2) @(posedge clk) #1;
		rst_n = 1;
		@(posedge clk) #1;
		chk("wdog addr", ra, 21'h000002);
		wd = 0;
		@(posedge clk) #1;
		chk("wdog sticky", ra, 21'h000002);
		$display("reset test done");
		wrap_up;
	end
endmodule : testbench
